/* File: verilog/dcw_ctl.sv */
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
// ************************************************************
// channel control word decoder with axi4-lite register access
// ************************************************************
module dcw_ctl #(
  parameter int AW    = 12,  // axi address width
  parameter int CNT_W = 10   // items left width
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             ce,           // freezes all state when low
  input  wire logic [AW-1:0]    s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [AW-1:0]    s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  input  wire logic             svc_req,      // arbiter grants service
  input  wire logic             svc_done,     // transfer ended early
  input  wire logic             item_done,    // one item moved
  input  wire logic [CNT_W-1:0] items_left,   // items left after current
  output logic                  busy,         // service period running
  output logic                  rearb,        // pulse: give up the bus
  output logic [10:0]           rearb_len,    // transfers per period
  output logic [2:0]            src_step_bytes,
  output logic [2:0]            dst_step_bytes,
  output logic [2:0]            src_item_bytes,
  output logic [2:0]            dst_item_bytes,
  output logic                  width_rsvd,   // reserved width code seen
  output logic [31:0]           src_addr,
  output logic [31:0]           dst_addr
);
  // ************************************************************
  // register file and axi write channel
  // ************************************************************
  logic [31:0]   src_end_q, src_end_d;  // src_end_pointer
  logic [31:0]   dst_end_q, dst_end_d;  // dst_end_pointer
  logic [31:0]   ctl_q, ctl_d;          // channel_control_word
  logic          aw_have_q, aw_have_d;  // address held
  logic          w_have_q, w_have_d;    // data held
  logic [AW-1:0] aw_q, aw_d;
  logic [31:0]   wd_q, wd_d;
  logic [3:0]    ws_q, ws_d;
  logic          awr_q, awr_d, wr_q, wr_d, bv_q, bv_d;
  logic [1:0]    br_q, br_d;
  logic [31:0]   merged;                // held word with strobes applied

  // take address and data in either order, answer once both are in
  always_comb begin
    src_end_d = src_end_q;
    dst_end_d = dst_end_q;
    ctl_d     = ctl_q;
    aw_have_d = aw_have_q;
    w_have_d  = w_have_q;
    aw_d      = aw_q;
    wd_d      = wd_q;
    ws_d      = ws_q;
    bv_d      = bv_q;
    br_d      = br_q;
    merged    = 32'h0000_0000;
    // accept address
    if (s_axi_awvalid && awr_q) begin
      aw_have_d = 1'b1;
      aw_d      = s_axi_awaddr;
    end
    // accept data
    if (s_axi_wvalid && wr_q) begin
      w_have_d = 1'b1;
      wd_d     = s_axi_wdata;
      ws_d     = s_axi_wstrb;
    end
    // response drained
    if (bv_q && s_axi_bready) begin
      bv_d = 1'b0;
    end
    // commit the write
    if (aw_have_q && w_have_q && !bv_q) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bv_d      = 1'b1;
      br_d      = dcw_pkg::RESP_OKAY;
      case (aw_q[11:0] & 12'hFFC)
        dcw_pkg::OFS_SRC_END: merged = src_end_q;
        dcw_pkg::OFS_DST_END: merged = dst_end_q;
        dcw_pkg::OFS_CTL:     merged = ctl_q;
        default:              merged = 32'h0000_0000;
      endcase
      for (int b = 0; b < 4; b++) begin
        if (ws_q[b]) merged[8*b +: 8] = wd_q[8*b +: 8];
      end
      // reserved bits are stored as written
      case (aw_q[11:0] & 12'hFFC)
        dcw_pkg::OFS_SRC_END: src_end_d = merged;
        dcw_pkg::OFS_DST_END: dst_end_d = merged;
        dcw_pkg::OFS_CTL:     ctl_d     = merged;
        default:              br_d      = dcw_pkg::RESP_SLVERR;
      endcase
    end
    // ready only while the holding slot is free
    awr_d = !aw_have_d && !(s_axi_awvalid && awr_q);
    wr_d  = !w_have_d && !(s_axi_wvalid && wr_q);
  end

  // register the write side
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_end_q <= dcw_pkg::REG_RST;
      dst_end_q <= dcw_pkg::REG_RST;
      ctl_q     <= dcw_pkg::REG_RST;
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      aw_q      <= '0;
      wd_q      <= 32'h0000_0000;
      ws_q      <= 4'h0;
      awr_q     <= 1'b0;
      wr_q      <= 1'b0;
      bv_q      <= 1'b0;
      br_q      <= dcw_pkg::RESP_OKAY;
    end else if (ce) begin
      src_end_q <= src_end_d;
      dst_end_q <= dst_end_d;
      ctl_q     <= ctl_d;
      aw_have_q <= aw_have_d;
      w_have_q  <= w_have_d;
      aw_q      <= aw_d;
      wd_q      <= wd_d;
      ws_q      <= ws_d;
      awr_q     <= awr_d;
      wr_q      <= wr_d;
      bv_q      <= bv_d;
      br_q      <= br_d;
    end
  end

  assign s_axi_awready = awr_q;
  assign s_axi_wready  = wr_q;
  assign s_axi_bvalid  = bv_q;
  assign s_axi_bresp   = br_q;

  // ************************************************************
  // axi read channel
  // ************************************************************
  logic              arr_q, arr_d, rv_q, rv_d;
  logic [31:0]       rd_q, rd_d;
  logic [1:0]        rr_q, rr_d;
  dcw_pkg::dcw_state_t st_q, st_d;
  logic [10:0]       beat_q, beat_d;

  // one read at a time: ready pulse, then data until taken
  always_comb begin
    arr_d = 1'b0;
    rv_d  = rv_q;
    rd_d  = rd_q;
    rr_d  = rr_q;
    if (rv_q && s_axi_rready) begin
      rv_d = 1'b0;
    end
    if (s_axi_arvalid && arr_q) begin
      rv_d = 1'b1;
      rr_d = dcw_pkg::RESP_OKAY;
      case (s_axi_araddr[11:0] & 12'hFFC)
        dcw_pkg::OFS_SRC_END: rd_d = src_end_q;
        dcw_pkg::OFS_DST_END: rd_d = dst_end_q;
        dcw_pkg::OFS_CTL:     rd_d = ctl_q;
        dcw_pkg::OFS_STATUS: begin
          rd_d = 32'h0000_0000;
          rd_d[2:0] = st_q;
          rd_d[dcw_pkg::STAT_BEAT_LSB +: 11] = beat_q;
        end
        default: begin
          rd_d = 32'h0000_0000;
          rr_d = dcw_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_arvalid && !rv_q && !arr_q) begin
      arr_d = 1'b1;
    end
  end

  // register the read side
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arr_q <= 1'b0;
      rv_q  <= 1'b0;
      rd_q  <= 32'h0000_0000;
      rr_q  <= dcw_pkg::RESP_OKAY;
    end else if (ce) begin
      arr_q <= arr_d;
      rv_q  <= rv_d;
      rd_q  <= rd_d;
      rr_q  <= rr_d;
    end
  end

  assign s_axi_arready = arr_q;
  assign s_axi_rvalid  = rv_q;
  assign s_axi_rdata   = rd_q;
  assign s_axi_rresp   = rr_q;

  // ************************************************************
  // service sequencer and decoded outputs
  // ************************************************************
  dcw_pkg::dcw_cfg_t cfg_q, cfg_d;        // settings of this period
  dcw_pkg::dcw_cfg_t word;                // fields of the stored word
  logic [10:0] len_q, len_d;
  logic        busy_q, busy_d, rb_q, rb_d, rsv_q, rsv_d;
  logic [2:0]  ssb_q, ssb_d, dsb_q, dsb_d, sib_q, sib_d, dib_q, dib_d;
  logic [31:0] sa_q, dsa_q, sa_gen, da_gen;

  // source and destination address generators
  dcw_addr_gen #(.CNT_W(CNT_W)) u_src_gen (
    .end_ptr (src_end_q),
    .step    (cfg_q.src_step),
    .left    (items_left),
    .addr    (sa_gen)
  );
  dcw_addr_gen #(.CNT_W(CNT_W)) u_dst_gen (
    .end_ptr (dst_end_q),
    .step    (cfg_q.dst_step),
    .left    (items_left),
    .addr    (da_gen)
  );

  // fetch the word, decode it once, count beats to the rearbitration
  always_comb begin
    word = '{ctl_q[dcw_pkg::DST_STEP_LSB +: 2], ctl_q[dcw_pkg::DST_WIDTH_LSB +: 2],
             ctl_q[dcw_pkg::SRC_STEP_LSB +: 2], ctl_q[dcw_pkg::SRC_WIDTH_LSB +: 2],
             ctl_q[dcw_pkg::ARB_LSB +: 4]};
    st_d   = st_q;
    cfg_d  = cfg_q;
    len_d  = len_q;
    beat_d = beat_q;
    busy_d = busy_q;
    rb_d   = 1'b0;
    ssb_d  = ssb_q;
    dsb_d  = dsb_q;
    sib_d  = sib_q;
    dib_d  = dib_q;
    rsv_d  = rsv_q;
    case (st_q)
      dcw_pkg::ST_IDLE: begin
        if (svc_req) st_d = dcw_pkg::ST_FETCH;
      end
      dcw_pkg::ST_FETCH: begin
        // settings are frozen here for the whole period
        cfg_d  = word;
        ssb_d  = dcw_pkg::dcw_step_bytes(word.src_step);
        dsb_d  = dcw_pkg::dcw_step_bytes(word.dst_step);
        sib_d  = dcw_pkg::dcw_width_bytes(word.src_width);
        dib_d  = dcw_pkg::dcw_width_bytes(word.dst_width);
        rsv_d  = (word.src_width == dcw_pkg::WIDTH_RSVD) ||
                 (word.dst_width == dcw_pkg::WIDTH_RSVD);
        len_d  = dcw_pkg::dcw_arb_len(word.arb);
        beat_d = 11'h000;
        busy_d = 1'b1;
        st_d   = dcw_pkg::ST_SERVE;
      end
      dcw_pkg::ST_SERVE: begin
        if (item_done && (beat_q + 11'h001 == len_q)) begin
          // period used up: hand the bus back
          rb_d   = 1'b1;
          busy_d = 1'b0;
          beat_d = beat_q + 11'h001;
          st_d   = dcw_pkg::ST_IDLE;
        end else if (svc_done) begin
          busy_d = 1'b0;
          st_d   = dcw_pkg::ST_IDLE;
        end else if (item_done) begin
          beat_d = beat_q + 11'h001;
        end
      end
      default: begin
        busy_d = 1'b0;
        st_d   = dcw_pkg::ST_IDLE;
      end
    endcase
  end

  // register the sequencer and the outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q   <= dcw_pkg::ST_IDLE;
      cfg_q  <= '0;
      len_q  <= 11'h001;
      beat_q <= 11'h000;
      busy_q <= 1'b0;
      rb_q   <= 1'b0;
      ssb_q  <= 3'h0;
      dsb_q  <= 3'h0;
      sib_q  <= 3'h0;
      dib_q  <= 3'h0;
      rsv_q  <= 1'b0;
      sa_q   <= 32'h0000_0000;
      dsa_q  <= 32'h0000_0000;
    end else if (ce) begin
      st_q   <= st_d;
      cfg_q  <= cfg_d;
      len_q  <= len_d;
      beat_q <= beat_d;
      busy_q <= busy_d;
      rb_q   <= rb_d;
      ssb_q  <= ssb_d;
      dsb_q  <= dsb_d;
      sib_q  <= sib_d;
      dib_q  <= dib_d;
      rsv_q  <= rsv_d;
      sa_q   <= sa_gen;
      dsa_q  <= da_gen;
    end
  end

  assign busy           = busy_q;
  assign rearb          = rb_q;
  assign rearb_len      = len_q;
  assign src_step_bytes = ssb_q;
  assign dst_step_bytes = dsb_q;
  assign src_item_bytes = sib_q;
  assign dst_item_bytes = dib_q;
  assign width_rsvd     = rsv_q;
  assign src_addr       = sa_q;
  assign dst_addr       = dsa_q;

  // ************************************************************
  // checks
  // ************************************************************
  AST_DST_STEP: assert property (@(posedge aclk) disable iff (!aresetn)
    busy_q |-> dsb_q == ((cfg_q.dst_step == 2'h3) ? 3'h0 : 3'(3'h1 << cfg_q.dst_step)))
    else $error("dst step bytes wrong");
  AST_DST_FIXED: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && busy_q && cfg_q.dst_step == 2'h3) |=> dsa_q == $past(dst_end_q))
    else $error("held dst address left end pointer");
  AST_DST_WIDTH: assert property (@(posedge aclk) disable iff (!aresetn)
    (busy_q && cfg_q.dst_width == 2'h2) |-> dib_q == 3'h4 && !rsv_q == (cfg_q.src_width != 2'h3))
    else $error("dst word width wrong");
  AST_SRC_STEP: assert property (@(posedge aclk) disable iff (!aresetn)
    (busy_q && cfg_q.src_step == 2'h1) |-> ssb_q == 3'h2)
    else $error("src half step wrong");
  AST_SRC_FIXED: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && busy_q && cfg_q.src_step == 2'h3) |=> sa_q == $past(src_end_q))
    else $error("held src address left end pointer");
  AST_SRC_WIDTH: assert property (@(posedge aclk) disable iff (!aresetn)
    (busy_q && cfg_q.src_width == 2'h3) |-> rsv_q && sib_q == 3'h0)
    else $error("reserved src width not flagged");
  AST_ARB_POW2: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(rb_q) |-> $past(beat_q) + 11'h001 == len_q && len_q == dcw_pkg::dcw_arb_len(cfg_q.arb))
    else $error("rearbitration at wrong count");
  AST_ARB_CAP: assert property (@(posedge aclk) disable iff (!aresetn)
    (busy_q && cfg_q.arb >= 4'hA) |-> len_q == 11'h400)
    else $error("capped rearbitration not 1024");
  AST_FETCH: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && st_q == dcw_pkg::ST_FETCH) |=> busy_q && cfg_q == $past(word))
    else $error("settings not taken from stored word");
endmodule

/* File: verilog/dcw_pkg.sv */
// ************************************************************
// constants, layouts and types of the control word decoder
// ************************************************************
package dcw_pkg;
  // register byte offsets
  localparam logic [11:0] OFS_SRC_END = 12'h000;  // src_end_pointer
  localparam logic [11:0] OFS_DST_END = 12'h004;  // dst_end_pointer
  localparam logic [11:0] OFS_CTL     = 12'h008;  // channel_control_word
  localparam logic [11:0] OFS_STATUS  = 12'h00C;  // service status, read only
  // control word field positions
  localparam int DST_STEP_LSB  = 30;  // dst_addr_step 31:30
  localparam int DST_WIDTH_LSB = 28;  // dst_item_width 29:28
  localparam int SRC_STEP_LSB  = 26;  // src_addr_step 27:26
  localparam int SRC_WIDTH_LSB = 24;  // src_item_width 25:24
  localparam int ARB_LSB       = 14;  // rearbitration_count 17:14
  // status field positions
  localparam int STAT_BEAT_LSB = 16;  // beats done in the period
  // reset values
  localparam logic [31:0] REG_RST = 32'h0000_0000;
  // codes
  localparam logic [1:0]  NO_STEP    = 2'h3;   // address held
  localparam logic [1:0]  WIDTH_RSVD = 2'h3;   // reserved width code
  localparam logic [3:0]  ARB_CAP    = 4'hA;   // first capped code
  localparam logic [10:0] ARB_MAX    = 11'h400; // 1024 transfers
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // service sequencer states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h1,
    ST_FETCH = 3'h2,
    ST_SERVE = 3'h4
  } dcw_state_t;

  // decoded fields of one control word
  typedef struct packed {
    logic [1:0] dst_step;
    logic [1:0] dst_width;
    logic [1:0] src_step;
    logic [1:0] src_width;
    logic [3:0] arb;
  } dcw_cfg_t;

  // step code to bytes; no step gives zero
  function automatic logic [2:0] dcw_step_bytes(input logic [1:0] c);
    case (c)
      2'h0:    return 3'h1;
      2'h1:    return 3'h2;
      2'h2:    return 3'h4;
      default: return 3'h0;
    endcase
  endfunction

  // width code to bytes; reserved gives zero
  function automatic logic [2:0] dcw_width_bytes(input logic [1:0] c);
    case (c)
      2'h0:    return 3'h1;
      2'h1:    return 3'h2;
      2'h2:    return 3'h4;
      default: return 3'h0;
    endcase
  endfunction

  // rearbitration code to transfer count, capped at 1024
  function automatic logic [10:0] dcw_arb_len(input logic [3:0] c);
    if (c >= ARB_CAP) return ARB_MAX;
    return 11'(11'h1 << c);
  endfunction
endpackage

/* File: verilog/dcw_addr_gen.sv */
`timescale 1ns/1ps
// ************************************************************
// item address from end pointer, step code and items left
// ************************************************************
module dcw_addr_gen #(
  parameter int CNT_W = 10
) (
  input  wire logic [31:0]      end_ptr,   // last address, inclusive
  input  wire logic [1:0]       step,      // address step code
  input  wire logic [CNT_W-1:0] left,      // items left after this one
  output logic      [31:0]      addr       // address of current item
);
  logic [31:0] back;  // distance back from the end pointer

  // a held address always reads the end pointer itself
  always_comb begin
    back = 32'(left) << step;
    if (step == dcw_pkg::NO_STEP) begin
      addr = end_ptr;
    end else begin
      addr = end_ptr - back;
    end
  end
endmodule

/* File: verif/dcw_xfer_model.sv */
`timescale 1ns/1ps
// ************************************************************
// transfer engine model: grants service and moves items
// ************************************************************
module dcw_xfer_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       start,       // request one service period
  input  wire logic       hold,        // stall item moves
  input  wire logic [1:0] gap_len,     // idle cycles between items
  input  wire logic [9:0] left_init,   // items left at period start
  input  wire logic       busy,        // service period running
  output logic            svc_req,
  output logic            item_done,
  output logic [9:0]      items_left
);
  logic [1:0] gap_q;  // idle cycles before the next item

  // one pulse per moved item, only while the period runs
  always_ff @(posedge aclk) begin
    svc_req   <= 1'b0;
    item_done <= 1'b0;
    if (!aresetn) begin
      gap_q      <= 2'h0;
      items_left <= 10'h000;
    end else if (start) begin
      svc_req    <= 1'b1;
      gap_q      <= 2'h3;  // leaves the decoded outputs settled first
      items_left <= left_init;
    end else if (busy && !hold) begin
      if (gap_q != 2'h0) begin
        gap_q <= gap_q - 2'h1;
      end else begin
        item_done <= 1'b1;
        gap_q     <= gap_len;  // zero gives back-to-back items
        if (items_left != 10'h000) begin
          items_left <= items_left - 10'h001;
        end
      end
    end
  end
endmodule

/* File: verif/dma_channel_control_word_tb_top.sv */
`timescale 1ns/1ps
// ************************************************************
// self-checking bench of the control word decoder
// ************************************************************
module dma_channel_control_word_tb_top;
  logic        aclk, aresetn, ce, start, hold, svc_done;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, svc_req, item_done, busy, rearb, width_rsvd;
  logic [31:0] s_axi_wdata, s_axi_rdata, src_addr, dst_addr, seed, cnt;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, gap_len;
  logic [9:0]  items_left, left_init;
  logic [10:0] rearb_len;
  logic [2:0]  src_step_bytes, dst_step_bytes, src_item_bytes, dst_item_bytes;
  logic        rearb_seen;  // a rearb pulse came in this period
  int          num_errors, num_checks, i;

  dcw_ctl uut (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .svc_req, .svc_done,
    .item_done, .items_left, .busy, .rearb, .rearb_len, .src_step_bytes,
    .dst_step_bytes, .src_item_bytes, .dst_item_bytes, .width_rsvd, .src_addr,
    .dst_addr);
  dcw_xfer_model xfer (.aclk, .aresetn, .start, .hold, .gap_len, .left_init, .busy,
    .svc_req, .item_done, .items_left);

  // ************************************************************
  // clock, item counter, watchdog
  // ************************************************************
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // counts items moved in the period and catches the rearb pulse
  always @(posedge aclk) begin
    if (start) begin
      cnt        <= 32'h0;
      rearb_seen <= 1'b0;
    end else begin
      if (item_done === 1'b1 && busy === 1'b1) cnt <= cnt + 32'h1;
      if (rearb === 1'b1) rearb_seen <= 1'b1;
    end
  end
  // cuts a hang short
  initial begin
    repeat (80000) @(posedge aclk);
    num_errors++;
    tally_and_finish();
  end

  // ************************************************************
  // helpers and expectations
  // ************************************************************
  function automatic logic [31:0] rnd();
    return $random(seed);
  endfunction
  // step or width code to bytes; code 3 gives zero
  function automatic logic [2:0] xbytes(input logic [1:0] c);
    return (c == 2'h3) ? 3'h0 : 3'(3'h1 << c);
  endfunction
  // transfers before giving up the bus
  function automatic logic [10:0] xlen(input logic [3:0] c);
    return (c >= 4'hA) ? 11'h400 : 11'(11'h1 << c);
  endfunction
  // address of the item, counted back from the end pointer
  function automatic logic [31:0] xaddr(input logic [31:0] e, input logic [1:0] s);
    return (s == 2'h3) ? e : e - ({22'h0, left_init} << s);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (num_errors == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ************************************************************
  // axi4-lite master tasks
  // ************************************************************
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d,
                           input logic [3:0] s, output logic [1:0] r);
    logic aw, w, b;
    aw = 1'b0;
    w  = 1'b0;
    b  = 1'b0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!b) begin
      @(posedge aclk);
      if (!aw && s_axi_awready === 1'b1) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready === 1'b1) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid === 1'b1) begin
        b = 1'b1;
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
    end
  endtask
  task automatic axi_read(input logic [11:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    logic t;
    t = 1'b0;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (s_axi_rvalid !== 1'b1 || !t) begin
      @(posedge aclk);
      if (!t && s_axi_arready === 1'b1) begin
        t = 1'b1;
        s_axi_arvalid <= 1'b0;
      end
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // ************************************************************
  // one service period with a random control word
  // ************************************************************
  task automatic period(input logic [3:0] c);
    logic [1:0]  wc, ss, ds, r;
    logic [31:0] se, de, old, nw, d;
    int          n;
    wc = c[1:0];  // equal width codes on both sides
    ss = (wc == 2'h3) ? 2'h3 : 2'(wc + rnd() % (3'h4 - wc));  // step not below width
    ds = (wc == 2'h3) ? 2'h3 : 2'(wc + rnd() % (3'h4 - wc));  // step not below width
    se = rnd();
    de = rnd();
    d  = rnd();
    axi_write(dcw_pkg::OFS_SRC_END, se, 4'hF, r);
    axi_write(dcw_pkg::OFS_DST_END, de, 4'hF, r);
    axi_read(dcw_pkg::OFS_CTL, old, r);
    nw = {ds, wc, ss, wc, old[23:18], c, d[13:0]};  // keeps bits 23:18 of the old word, bits 13:0 random
    axi_write(dcw_pkg::OFS_CTL, nw, 4'hF, r);
    axi_read(dcw_pkg::OFS_CTL, d, r);
    chk(d, nw);
    left_init <= 10'(rnd());
    gap_len   <= 2'(rnd());
    start     <= 1'b1;
    @(posedge aclk);
    start <= 1'b0;
    n = 0;
    while (busy !== 1'b1 && n < 20) begin
      @(negedge aclk);
      n++;
    end
    @(negedge aclk);
    chk(dst_step_bytes, xbytes(ds));
    chk(src_step_bytes, xbytes(ss));
    chk(dst_item_bytes, xbytes(wc));
    chk(src_item_bytes, xbytes(wc));
    chk(width_rsvd, wc == 2'h3);
    chk(rearb_len, xlen(c));
    chk(dst_addr, xaddr(de, ds));
    chk(src_addr, xaddr(se, ss));
    // a new word in mid-period must not disturb the running settings
    if (c >= 4'h4) axi_write(dcw_pkg::OFS_CTL, ~nw, 4'hF, r);
    n = 0;
    while (rearb !== 1'b1 && n < 6000) begin
      @(negedge aclk);
      n++;
    end
    if (n >= 6000) num_errors++;  // the rearb pulse never came
    chk(cnt, xlen(c));
    chk(rearb_len, xlen(c));
    chk(src_step_bytes, xbytes(ss));
    chk(busy, 1'b0);
    @(negedge aclk);
    chk(rearb, 1'b0);
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin : main
    logic [31:0] d;
    logic [1:0]  r;
    {aresetn, start, hold, svc_done, s_axi_awvalid, s_axi_wvalid} = 6'h00;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 60'h0;
    {gap_len, left_init} = 12'h000;
    ce         = 1'b1;
    seed       = 32'hAB53;
    num_errors = 0;
    num_checks = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // reset values, status idle, unmapped place refused
    chk(rearb_len, 32'h1);
    for (i = 0; i < 5; i++) begin
      axi_read(12'(i * 4), d, r);
      chk(d, (i == 3) ? 32'h1 : 32'h0);
      chk(r, (i == 4) ? dcw_pkg::RESP_SLVERR : dcw_pkg::RESP_OKAY);
    end
    axi_write(12'h010, rnd(), 4'hF, r);
    chk(r, dcw_pkg::RESP_SLVERR);
    // byte lanes merge into the stored word
    axi_write(dcw_pkg::OFS_DST_END, 32'hFFFF_FFFF, 4'h3, r);
    axi_read(dcw_pkg::OFS_DST_END, d, r);
    chk(d, 32'h0000_FFFF);
    // every rearbitration code with random fields
    for (i = 0; i < 16; i++) period(4'(i));
    // early end: no rearb pulse, back to idle
    @(posedge aclk);
    hold  <= 1'b1;
    start <= 1'b1;
    @(posedge aclk);
    start <= 1'b0;
    repeat (4) @(posedge aclk);
    chk(busy, 1'b1);
    // a low clock enable freezes the period, early end included
    ce       <= 1'b0;
    svc_done <= 1'b1;
    repeat (2) @(posedge aclk);
    chk(busy, 1'b1);
    ce <= 1'b1;
    @(posedge aclk);
    svc_done <= 1'b0;
    repeat (3) @(negedge aclk);
    chk(busy, 1'b0);
    chk(rearb_seen, 1'b0);
    tally_and_finish();
  end
endmodule
